/* File: logic/ssup_pkg.sv */
// Shared constants and types for the streaming source user port
package ssup_pkg;
    // Lane and sideband geometry
    localparam int          SSUP_LANES_DEF   = 1;
    localparam int          SSUP_WORD_W      = 64;
    localparam int          SSUP_SB_W        = 8;
    localparam int          SSUP_ERR_W       = 4;
    // Error vector bit positions
    localparam int          SSUP_ERR_OVF     = 0;
    localparam int          SSUP_ERR_SEU_FIX = 1;
    localparam int          SSUP_ERR_SEU_BAD = 2;
    localparam int          SSUP_ERR_GAP     = 3;
    // Device timing in cycles of ref_clk, and FIFO depth in entries
    localparam int          SSUP_RST_SEQ_CYC = 16;
    localparam int          SSUP_INIT_CYC    = 32;
    localparam int          SSUP_BURST_GAP   = 2;
    localparam int          SSUP_FIFO_DEPTH  = 8;
    // Controller register offsets (byte addresses)
    localparam logic [11:0] SSUP_REG_CTRL    = 12'h000;
    localparam logic [11:0] SSUP_REG_LEN     = 12'h004;
    localparam logic [11:0] SSUP_REG_STAT    = 12'h008;
    // Controller field positions and reset values
    localparam int          SSUP_CTRL_GO     = 0;
    localparam int          SSUP_CTRL_CONT   = 1;
    localparam int          SSUP_CTRL_LAST   = 2;
    localparam int          SSUP_LEN_LSB     = 0;
    localparam int          SSUP_UNUSED_LSB  = 16;
    localparam int          SSUP_STAT_ERR    = 4;
    localparam logic [31:0] SSUP_CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] SSUP_LEN_RST     = 32'h0000_0004;

    // Generator states of the user end
    typedef enum logic [1:0] {SSUP_IDLE, SSUP_RUN, SSUP_DONE} ssup_state_t;
endpackage : ssup_pkg

/* File: logic/ssup_if.sv */
// Interface joining the streaming source device end and its user end
`timescale 1ns/1ps
interface ssup_if #(parameter int LANES = ssup_pkg::SSUP_LANES_DEF);
    import ssup_pkg::*;
    // Stream from user to device
    logic [SSUP_WORD_W*LANES-1:0] data;
    logic                         valid;
    logic                         burst_first_flag;
    logic                         burst_last_flag;
    logic [SSUP_SB_W-1:0]         sideband;
    logic                         crc_inject;
    // Status from device to user
    logic [SSUP_ERR_W-1:0]        err;
    logic                         link_up;
    logic                         user_rst;

    modport dev (
        input  data, valid, burst_first_flag, burst_last_flag, sideband, crc_inject,
        output err, link_up, user_rst
    );
    modport usr (
        output data, valid, burst_first_flag, burst_last_flag, sideband, crc_inject,
        input  err, link_up, user_rst
    );
endinterface : ssup_if

/* File: logic/ssup_dev.sv */
// Device end: adaptation FIFO, error vector, reset sequence and link-ready
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RQ1) User puts unused lane-word count on sideband
// (RQ2) Single lane: sideband at burst end zero
// (RQ3) Valid marks exactly the payload cycles
// (RQ4) Burst mode: first flag on first word
// (RQ5) Continuous mode: first flag only once
// (RQ6) Burst mode: last flag on final word
// (RQ7) Continuous mode: last flag optional, accepted
// (RQ8) Device drives 4-bit error vector
// (RQ9) Bit 0 flags adaptation FIFO overflow
// (RQ10) Bit 1 flags corrected upset, ECC on
// (RQ11) Bit 2 flags uncorrectable upset, ECC on
// (RQ12) Bit 3 flags burst gap mismatch
// (RQ13) Inject request corrupts CRC when enabled
// (RQ14) Master reset asynchronous, active high
// (RQ15) User reset held until sequence completes
// (RQ16) Link-ready once initialisation finished
// (RQ17) Data is 64 bits per lane
// (RQ18) User idle until link ready
module ssup_dev
    import ssup_pkg::*;
#(
    parameter int LANES     = SSUP_LANES_DEF,
    parameter int DEPTH     = SSUP_FIFO_DEPTH,
    parameter int BURST_GAP = SSUP_BURST_GAP,
    parameter bit ECC_EN    = 1'b1
) (
    // Clock and resets
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         master_rst,
    // Configuration pins
    input  wire logic                         burst_mode,
    input  wire logic                         crc_inj_en,
    // User port
    ssup_if.dev                               up,
    // Link side
    output logic [SSUP_WORD_W*LANES-1:0]      tx_data,
    output logic [SSUP_SB_W-1:0]              tx_sideband,
    output logic                              tx_first,
    output logic                              tx_last,
    output logic                              tx_valid,
    output logic                              tx_crc_corrupt,
    input  wire logic                         tx_ready,
    // Upset injection for the main and the copy storage
    input  wire logic                         seu_flip_main,
    input  wire logic                         seu_flip_copy
);
    localparam int DW = SSUP_WORD_W*LANES + SSUP_SB_W + 2;
    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser: async assert, clocked release [RQ14]
    logic mrst_meta_q;
    logic mrst_sync_q;
    always_ff @(posedge ref_clk or posedge master_rst) begin
        if (master_rst) begin
            mrst_meta_q <= 1'b1;
            mrst_sync_q <= 1'b1;
        end else begin
            mrst_meta_q <= 1'b0;
            mrst_sync_q <= mrst_meta_q;
        end
    end
    wire core_rst = rst | mrst_sync_q;

    // Pin synchronisers for the injection enable and the mode pin
    logic inj_meta_q;
    logic inj_en_q;
    logic mode_meta_q;
    logic burst_q;
    always_ff @(posedge ref_clk) begin
        inj_meta_q  <= crc_inj_en;
        inj_en_q    <= inj_meta_q;
        mode_meta_q <= burst_mode;
        burst_q     <= mode_meta_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequence then initialisation count
    logic [7:0] seq_q;
    logic       user_rst_q;
    logic       link_up_q;
    wire        seq_end  = (seq_q == 8'(SSUP_RST_SEQ_CYC));
    wire        init_end = (seq_q == 8'(SSUP_RST_SEQ_CYC + SSUP_INIT_CYC));
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            seq_q      <= 8'h00;
            user_rst_q <= 1'b1;
            link_up_q  <= 1'b0;
        end else begin
            if (!init_end) seq_q <= seq_q + 8'h01;
            if (seq_end) user_rst_q <= 1'b0;   // [RQ15]
            if (init_end) link_up_q <= 1'b1;   // [RQ16]
        end
    end
    assign up.user_rst = user_rst_q;           // [RQ15]
    assign up.link_up  = link_up_q;

    ////////////////////////////////////////////////////////////////////////////
    // Adaptation FIFO with duplicated storage and per-copy parity
    logic [DW-1:0] mem_main [DEPTH];
    logic [DW-1:0] mem_copy [DEPTH];
    logic [DEPTH-1:0] par_main;
    logic [DEPTH-1:0] par_copy;
    logic [AW:0]   wr_q;
    logic [AW:0]   rd_q;

    // Input is only taken once the link is up; earlier data is dropped [RQ18]
    wire [DW-1:0] wr_word = {up.burst_first_flag, up.burst_last_flag, up.sideband, up.data}; // [RQ17]
    wire fifo_full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire fifo_empty = (wr_q == rd_q);
    wire push       = up.valid && link_up_q && !user_rst_q;  // [RQ3]
    wire do_wr      = push && !fifo_full;
    wire overflow   = push && fifo_full;                     // [RQ9]
    wire do_rd      = !fifo_empty && (!tx_valid || tx_ready);

    // Storage; an upset flips one bit of a chosen copy at the write slot
    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem_main[wr_q[AW-1:0]] <= wr_word ^ {{(DW-1){1'b0}}, seu_flip_main};
            mem_copy[wr_q[AW-1:0]] <= wr_word ^ {{(DW-1){1'b0}}, seu_flip_copy};
            par_main[wr_q[AW-1:0]] <= ^wr_word;
            par_copy[wr_q[AW-1:0]] <= ^wr_word;
        end
    end

    // Pointers
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_wr) wr_q <= wr_q + (AW+1)'(1);
            if (do_rd) rd_q <= rd_q + (AW+1)'(1);
        end
    end

    // Check the head word; a good copy repairs a bad main copy [RQ10] [RQ11]
    wire [AW-1:0] hd      = rd_q[AW-1:0];
    wire          main_ok = (^mem_main[hd]) == par_main[hd];
    wire          copy_ok = (^mem_copy[hd]) == par_copy[hd];
    wire [DW-1:0] rd_word = (main_ok || !ECC_EN) ? mem_main[hd] : mem_copy[hd];
    wire          seu_fix = ECC_EN && do_rd && !main_ok && copy_ok;
    wire          seu_bad = ECC_EN && do_rd && !main_ok && !copy_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Link-side output register
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            tx_valid <= 1'b0;
            tx_data  <= '0;
            tx_sideband <= '0;
            tx_first <= 1'b0;
            tx_last  <= 1'b0;
        end else if (do_rd) begin
            tx_valid    <= 1'b1;
            tx_first    <= rd_word[DW-1];
            tx_last     <= rd_word[DW-2];
            tx_sideband <= rd_word[DW-3 -: SSUP_SB_W];
            tx_data     <= rd_word[SSUP_WORD_W*LANES-1:0];
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // CRC corruption follows the request only while injection is enabled
    always_ff @(posedge ref_clk) begin
        if (core_rst) tx_crc_corrupt <= 1'b0;
        else          tx_crc_corrupt <= up.crc_inject && inj_en_q;  // [RQ13]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst gap monitor, counting every cycle of ref_clk between bursts.
    // Continuous mode never checks, so a missing or present last is fine.
    logic [15:0] gap_q;
    logic        in_gap_q;
    wire gap_bad = burst_q && in_gap_q && push && up.burst_first_flag
                   && (gap_q != 16'(BURST_GAP));           // [RQ12] [RQ7]
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            gap_q    <= 16'h0000;
            in_gap_q <= 1'b0;
        end else if (push && up.burst_last_flag) begin
            gap_q    <= 16'h0000;
            in_gap_q <= burst_q;                            // [RQ7]
        end else if (push && up.burst_first_flag) begin
            in_gap_q <= 1'b0;
        end else if (in_gap_q && gap_q != 16'hFFFF) begin
            gap_q    <= gap_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error vector: one-cycle pulses, registered [RQ8]
    logic [SSUP_ERR_W-1:0] err_q;
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            err_q <= '0;
        end else begin
            err_q[SSUP_ERR_OVF]     <= overflow;   // [RQ9]
            err_q[SSUP_ERR_SEU_FIX] <= seu_fix;    // [RQ10]
            err_q[SSUP_ERR_SEU_BAD] <= seu_bad;    // [RQ11]
            err_q[SSUP_ERR_GAP]     <= gap_bad;    // [RQ12]
        end
    end
    assign up.err = err_q;                         // [RQ8]
endmodule : ssup_dev

/* File: logic/ssup_usr.sv */
// User end: APB-controlled burst generator driving the streaming source port
`timescale 1ns/1ps
module ssup_usr
    import ssup_pkg::*;
#(
    parameter int LANES = SSUP_LANES_DEF
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Error injection request
    input  wire logic        crc_inject_req,
    // Streaming port
    ssup_if.usr              dn
);
    ssup_state_t st_q;
    logic [31:0] ctrl_q;
    logic [31:0] len_q;
    logic [3:0]  err_q;
    logic [15:0] cnt_q;
    logic        first_done_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait state
    wire acc    = psel && penable;
    wire hit_c  = (paddr == SSUP_REG_CTRL);
    wire hit_l  = (paddr == SSUP_REG_LEN);
    wire hit_s  = (paddr == SSUP_REG_STAT);
    wire wr_c   = acc && pwrite && hit_c;
    wire wr_s   = acc && pwrite && hit_s;
    wire go     = wr_c && pwdata[SSUP_CTRL_GO] && (st_q != SSUP_RUN);
    wire [31:0] stat = {24'h000000, err_q, 1'b0, dn.user_rst, dn.link_up, st_q == SSUP_RUN};
    assign pready  = 1'b1;
    assign pslverr = acc && !(hit_c || hit_l || hit_s);

    // Registers; error bits are sticky, set wins over write-one-clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= SSUP_CTRL_RST;
            len_q  <= SSUP_LEN_RST;
            err_q  <= 4'h0;
            prdata <= 32'h0000_0000;
        end else begin
            if (wr_c) ctrl_q <= pwdata & 32'h0000_0006;
            if (acc && pwrite && hit_l) len_q <= pwdata;
            err_q <= (err_q & ~(wr_s ? pwdata[SSUP_STAT_ERR +: 4] : 4'h0)) | dn.err;
            if (psel && !penable && !pwrite) begin
                if (hit_c)      prdata <= ctrl_q;
                else if (hit_l) prdata <= len_q;
                else if (hit_s) prdata <= stat;
                else            prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Generator; waits for link up and released reset [RQ18]
    wire        cont  = ctrl_q[SSUP_CTRL_CONT];
    wire        ready = dn.link_up && !dn.user_rst;
    wire [15:0] len   = (len_q[15:0] == 16'h0000) ? 16'h0001 : len_q[15:0];
    wire        final_w = (cnt_q == len - 16'h0001);
    wire        run   = (st_q == SSUP_RUN) && ready;
    wire        last_now = run && final_w && (!cont || ctrl_q[SSUP_CTRL_LAST]);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q  <= SSUP_IDLE;
            cnt_q <= 16'h0000;
            first_done_q <= 1'b0;
        end else begin
            case (st_q)
                SSUP_IDLE, SSUP_DONE: begin
                    cnt_q <= 16'h0000;
                    if (go) st_q <= SSUP_RUN;
                end
                SSUP_RUN: begin
                    if (run) begin
                        cnt_q <= cnt_q + 16'h0001;
                        first_done_q <= cont;   // Burst runs rearm the single first flag
                        if (final_w) st_q <= SSUP_DONE;
                    end
                end
                default: st_q <= SSUP_IDLE;
            endcase
        end
    end

    // Stream outputs, registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dn.valid <= 1'b0;
            dn.burst_first_flag <= 1'b0;
            dn.burst_last_flag  <= 1'b0;
            dn.sideband <= '0;
            dn.data     <= '0;
            dn.crc_inject <= 1'b0;
        end else begin
            dn.crc_inject <= crc_inject_req;
            dn.valid <= run;                                             // [RQ3]
            dn.data  <= {LANES{48'h000000000000, cnt_q}};                // [RQ17]
            dn.burst_first_flag <= run && (cnt_q == 16'h0000)
                                   && (!cont || !first_done_q);          // [RQ4] [RQ5]
            dn.burst_last_flag  <= last_now;                              // [RQ6] [RQ7]
            dn.sideband <= (last_now && LANES > 1)
                           ? len_q[SSUP_UNUSED_LSB +: 8] : 8'h00;        // [RQ1] [RQ2]
        end
    end
endmodule : ssup_usr

/* File: bench/ssup_assertions.sv */
// Checker watching the streaming port between the device and user ends
`timescale 1ns/1ps
module ssup_assertions
    import ssup_pkg::*;
#(
    parameter int LANES = SSUP_LANES_DEF
) (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // Stream from the user end
    input wire logic                  valid,
    input wire logic                  burst_first_flag,
    input wire logic                  burst_last_flag,
    input wire logic [SSUP_SB_W-1:0]  sideband,
    // Status from the device end
    input wire logic [SSUP_ERR_W-1:0] err,
    input wire logic                  link_up,
    input wire logic                  user_rst
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // Stream side, driven by the user end
    a_idle_until_up: assert property (valid |-> link_up && !user_rst)
        else $error("Payload offered before the link was ready");
    a_first_valid: assert property (burst_first_flag |-> valid)
        else $error("First flag without payload");
    a_last_valid: assert property (burst_last_flag |-> valid)
        else $error("Last flag without payload");
    a_sb_mid_zero: assert property (valid && !burst_last_flag |-> sideband == 8'h00)
        else $error("Sideband not zero inside a burst");
    a_sb_single_lane: assert property (burst_last_flag && LANES == 1 |-> sideband == 8'h00)
        else $error("Sideband not zero at burst end on one lane");
    ////////////////////////////////////////////////////////////////////////////
    // Status side, driven by the device end
    // Reset itself is the antecedent here, so this one is never disabled
    a_rst_held: assert property (disable iff (1'b0) rst |=> user_rst)
        else $error("User reset low after a reset cycle");
    a_rst_release: assert property ($fell(rst) |-> user_rst [*8])
        else $error("User reset released before its sequence");
    a_link_not_rst: assert property (user_rst |-> !link_up)
        else $error("Link ready while user reset is high");
    a_gap_cause: assert property (err[SSUP_ERR_GAP] |-> $past(valid && burst_first_flag))
        else $error("Gap error without a burst start before it");
    a_ovf_cause: assert property (err[SSUP_ERR_OVF] |-> $past(valid))
        else $error("Overflow error without an offered word");
endmodule : ssup_assertions

/* File: bench/tb.sv */
// Testbench joining the user end and device end of the streaming port
`timescale 1ns/1ps
module tb
    import ssup_pkg::*;
;
    // Pins, APB and link side
    logic        ref_clk, rst, master_rst, burst_mode, crc_inj_en;
    logic        tx_ready, seu_main, seu_copy, crc_req;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        tx_first, tx_last, tx_valid, tx_crc_corrupt, rd_err;
    logic [63:0] tx_data;
    logic [7:0]  tx_sideband;
    int          n_mismatch, comparisons, n_beat, n_first, n_last, n_bad_data;
    int          n_err [4];
    ////////////////////////////////////////////////////////////////////////////
    // Both ends face each other; the checker sits beside the interface
    ssup_if #(.LANES(1)) u_ssup_if ();
    ssup_dev #(.LANES(1)) u_ssup_dev (.ref_clk(ref_clk), .rst(rst), .master_rst(master_rst),
        .burst_mode(burst_mode), .crc_inj_en(crc_inj_en), .up(u_ssup_if),
        .tx_data(tx_data), .tx_sideband(tx_sideband),
        .tx_first(tx_first), .tx_last(tx_last), .tx_valid(tx_valid), .tx_crc_corrupt(tx_crc_corrupt),
        .tx_ready(tx_ready), .seu_flip_main(seu_main), .seu_flip_copy(seu_copy));
    ssup_usr #(.LANES(1)) u_ssup_usr (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crc_inject_req(crc_req), .dn(u_ssup_if));
    ssup_assertions #(.LANES(1)) u_ssup_assertions (.ref_clk(ref_clk), .rst(rst),
        .valid(u_ssup_if.valid), .burst_first_flag(u_ssup_if.burst_first_flag),
        .burst_last_flag(u_ssup_if.burst_last_flag), .sideband(u_ssup_if.sideband),
        .err(u_ssup_if.err), .link_up(u_ssup_if.link_up), .user_rst(u_ssup_if.user_rst));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Counts link beats, error pulses and payload that is not the beat index
    always @(posedge ref_clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_data !== 64'(n_beat) || tx_sideband !== 8'h00) n_bad_data++;
            n_beat++;
            n_first += int'(tx_first);
            n_last += int'(tx_last);
        end
        for (int i = 0; i < 4; i++) n_err[i] += int'(u_ssup_if.err[i]);
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tally_and_finish();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // Ends one cycle after release so the next setup never lands in the same step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd_v = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (k >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : apb
    task automatic wait_stat(input int b, input logic v);
        int k;
        k = 0;
        do begin
            apb(1'b0, SSUP_REG_STAT, 32'h0);
            k++;
        end while (rd_v[b] !== v && k < 200);
        if (k >= 200) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : wait_stat
    // Clears the tallies, starts one run and waits for its beats to leave
    task automatic run(input logic [31:0] ctl, input logic [31:0] len, input int beats);
        int k;
        n_beat = 0;
        n_first = 0;
        n_last = 0;
        n_bad_data = 0;
        for (int i = 0; i < 4; i++) n_err[i] = 0;
        apb(1'b1, SSUP_REG_LEN, len);
        apb(1'b1, SSUP_REG_CTRL, ctl);
        wait_stat(0, 1'b0);
        for (k = 0; k < 200 && n_beat < beats; k++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        if (k >= 200) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk("user_rst in reset", 32'h1, 32'(u_ssup_if.user_rst));
        rst <= 1'b0;
        wait_stat(1, 1'b1);
        chk("user_rst after init", 32'h0, 32'(u_ssup_if.user_rst));
        apb(1'b0, SSUP_REG_CTRL, 32'h0);
        chk("CTRL reset", SSUP_CTRL_RST, rd_v);
        apb(1'b0, SSUP_REG_LEN, 32'h0);
        chk("LEN reset", SSUP_LEN_RST, rd_v);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped error", 32'h1, 32'(rd_err));
    endtask : t_reset
    task automatic t_burst();
        burst_mode <= 1'b1;
        run(32'h1, 32'h3, 3);
        chk("beats", 32'h3, 32'(n_beat));
        chk("payload", 32'h0, 32'(n_bad_data));
        chk("first flags", 32'h1, 32'(n_first));
        chk("last flags", 32'h1, 32'(n_last));
        // Gap since the previous burst is far above the configured two cycles
        run(32'h1, 32'h2, 2);
        chk("gap errors", 32'h1, 32'(n_err[SSUP_ERR_GAP]));
        apb(1'b0, SSUP_REG_STAT, 32'h0);
        chk("sticky gap", 32'h1, 32'(rd_v[7]));
        apb(1'b1, SSUP_REG_STAT, 32'h80);
        apb(1'b0, SSUP_REG_STAT, 32'h0);
        chk("gap cleared", 32'h0, 32'(rd_v[7]));
    endtask : t_burst
    task automatic t_ovf();
        tx_ready <= 1'b0;
        run(32'h1, 32'hC, 0);
        // The FIFO plus the held output word survive; the rest is lost
        chk("overflows", 32'(12 - SSUP_FIFO_DEPTH - 1), 32'(n_err[SSUP_ERR_OVF]));
        tx_ready <= 1'b1;
        repeat (30) @(posedge ref_clk);
        chk("beats kept", 32'(SSUP_FIFO_DEPTH + 1), 32'(n_beat));
        chk("kept payload", 32'h0, 32'(n_bad_data));
    endtask : t_ovf
    task automatic t_ecc();
        seu_main <= 1'b1;
        run(32'h1, 32'h2, 2);
        chk("corrected", 32'h2, 32'(n_err[SSUP_ERR_SEU_FIX]));
        chk("repaired payload", 32'h0, 32'(n_bad_data));
        seu_copy <= 1'b1;
        run(32'h1, 32'h2, 2);
        chk("uncorrectable", 32'h2, 32'(n_err[SSUP_ERR_SEU_BAD]));
        chk("flipped payload", 32'h2, 32'(n_bad_data));
        seu_main <= 1'b0;
        seu_copy <= 1'b0;
    endtask : t_ecc
    task automatic t_crc();
        crc_req <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("corrupt, disabled", 32'h0, 32'(tx_crc_corrupt));
        crc_inj_en <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("corrupt, enabled", 32'h1, 32'(tx_crc_corrupt));
        crc_req <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("corrupt, released", 32'h0, 32'(tx_crc_corrupt));
    endtask : t_crc
    task automatic t_cont();
        burst_mode <= 1'b0;
        run(32'h7, 32'h4, 4);
        chk("cont firsts", 32'h1, 32'(n_first));
        chk("cont lasts", 32'h1, 32'(n_last));
        chk("cont gap", 32'h0, 32'(n_err[SSUP_ERR_GAP]));
        run(32'h3, 32'h4, 4);
        chk("open beats", 32'h4, 32'(n_beat));
        chk("open lasts", 32'h0, 32'(n_last));
        chk("open firsts", 32'h0, 32'(n_first));
    endtask : t_cont
    task automatic t_master();
        master_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("master user_rst", 32'h1, 32'(u_ssup_if.user_rst));
        chk("master link", 32'h0, 32'(u_ssup_if.link_up));
        master_rst <= 1'b0;
        wait_stat(1, 1'b1);
        chk("relinked", 32'h0, 32'(u_ssup_if.user_rst));
    endtask : t_master
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, tx_ready} = 2'b11;
        {master_rst, burst_mode, crc_inj_en, seu_main, seu_copy, crc_req} = 6'h00;
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        repeat (5) @(posedge ref_clk);
        t_reset();
        t_burst();
        t_ovf();
        t_ecc();
        t_crc();
        t_cont();
        t_master();
        tally_and_finish();
    end
endmodule : tb
